//--- logic/psa_defines.vh
// Constants for the predicate-set ALU slice: fields, opcodes, values
`ifndef PSA_DEFINES_VH
`define PSA_DEFINES_VH

// ==========================================
// Group shape
`define PSA_SLOTS 5
`define PSA_THREAD_W 6
`define PSA_THREADS 64

// ==========================================
// First word fields (bit positions)
`define PSA_W0_SRC0_NEG 12
`define PSA_W0_SRC1_NEG 25

// ==========================================
// Second word fields (bit positions)
`define PSA_W1_SRC0_ABS 0
`define PSA_W1_SRC1_ABS 1
`define PSA_W1_OMOD_LO 5
`define PSA_W1_OMOD_HI 6
`define PSA_W1_INST_LO 7
`define PSA_W1_INST_HI 17

// ==========================================
// Opcodes of the instruction field
`define PSA_OP_NOP 11'h01a
`define PSA_OP_OR 11'h031
`define PSA_OP_PRED_CLEAR 11'h026
`define PSA_OP_PRED_INVERT 11'h024
`define PSA_OP_PRED_POP 11'h025
`define PSA_OP_PRED_RESTORE 11'h027
`define PSA_OP_PRED_FP_EQ 11'h020
`define PSA_OP_PRED_DBL_EQ 11'h0c8
`define PSA_OP_PRED_INT_EQ 11'h042
`define PSA_OP_PRED_FP_PUSH_EQ 11'h028
`define PSA_OP_PRED_INT_PUSH_EQ 11'h048

// ==========================================
// Output modifier codes
`define PSA_OMOD_NONE 2'h0
`define PSA_OMOD_MUL2 2'h1
`define PSA_OMOD_MUL4 2'h2
`define PSA_OMOD_DIV2 2'h3

// ==========================================
// Data values
`define PSA_F_ZERO 32'h00000000
`define PSA_F_ONE 32'h3f800000
`define PSA_F_MAX 32'h7f7fffff
`define PSA_ALL_ONES 32'hffffffff
`define PSA_I_ZERO 32'h00000000
`define PSA_PRED_EXEC 1'b1
`define PSA_PRED_SKIP 1'b0

`endif

//--- logic/psa_fadd.v
// Single-precision adder, denormals flushed, truncating
`timescale 1ns/1ps

module psa_fadd (
	input wire [31:0] a, // First addend
	input wire [31:0] b, // Second addend
	output reg [31:0] y // Sum
);
	reg [7:0] ea;
	reg [7:0] eb;
	reg [7:0] el;
	reg [7:0] d;
	reg sl;
	reg ss;
	reg [23:0] ml;
	reg [23:0] ms;
	reg [24:0] sum;
	reg [4:0] lz;
	reg [9:0] e_out;
	reg found;
	integer k;

	always @* begin
		ea = a[30:23];
		eb = b[30:23];
		el = 8'h00;
		d = 8'h00;
		sl = 1'b0;
		ss = 1'b0;
		ml = 24'h000000;
		ms = 24'h000000;
		sum = 25'h0000000;
		lz = 5'h00;
		e_out = 10'h000;
		found = 1'b0;
		y = 32'h00000000;
		if (ea == 8'hff) begin
			y = a;
		end else if (eb == 8'hff) begin
			y = b;
		end else begin
			// Larger magnitude first; denormal inputs count as zero
			if ({ea, a[22:0]} >= {eb, b[22:0]}) begin
				el = ea;
				sl = a[31];
				ss = b[31];
				ml = (ea == 8'h00) ? 24'h000000 : {1'b1, a[22:0]};
				ms = (eb == 8'h00) ? 24'h000000 : {1'b1, b[22:0]};
				d = ea - eb;
			end else begin
				el = eb;
				sl = b[31];
				ss = a[31];
				ml = (eb == 8'h00) ? 24'h000000 : {1'b1, b[22:0]};
				ms = (ea == 8'h00) ? 24'h000000 : {1'b1, a[22:0]};
				d = eb - ea;
			end
			ms = (d > 8'h17) ? 24'h000000 : (ms >> d);
			if (sl == ss) begin
				sum = {1'b0, ml} + {1'b0, ms};
			end else begin
				sum = {1'b0, ml} - {1'b0, ms};
			end
			if (sum == 25'h0000000) begin
				y = 32'h00000000;
			end else if (sum[24]) begin
				e_out = {2'b00, el} + 10'h001;
				if (e_out >= 10'h0ff) begin
					y = {sl, 8'hff, 23'h000000};
				end else begin
					y = {sl, e_out[7:0], sum[23:1]};
				end
			end else begin
				for (k = 23; k >= 0; k = k - 1) begin
					if (!found && sum[k]) begin
						found = 1'b1;
						lz = 5'd23 - k[4:0];
					end
				end
				sum = sum << lz;
				if ({2'b00, el} <= {5'h00, lz}) begin
					y = {sl, 31'h00000000};
				end else begin
					e_out = {2'b00, el} - {5'h00, lz};
					y = {sl, e_out[7:0], sum[22:0]};
				end
			end
		end
	end

endmodule

//--- logic/psa_alu.v
// Predicate-set ALU slice: one instruction group per cycle, five slots
`timescale 1ns/1ps
`include "psa_defines.vh"

// What this block does
// - OR opcode writes source0 OR source1
// - Clear writes max float, predicate skip
// - Invert: 1.0 gives 0.0 execute, else skip
// - Pop: src0<=src1 gives 0.0 execute, else difference
// - Float equal: 0.0 execute, else 1.0 skip
// - Double equal on channel pairs, zero or ones
// - Double compare: zeros/denormals equal, NaN never
// - Predicate ops except restore set execute or skip result
// - Double compare uses slot pair 0-1 or 2-3
// - Double input modifiers only in X and Z
// - Double compare result takes no output modifier
// - Integer equal sets predicate kill update
// - Float push: both zero execute, else increment
// - Integer push: src1 int zero, src0 float zero
// - Two instruction words, opcode in second word
// - Unused slot acts as NOP, invalidates previous
module psa_alu (
	input wire clock, // Core clock
	input wire rst_n, // Asynchronous reset, active low
	input wire grp_valid, // Instruction group presented this cycle
	input wire [`PSA_THREAD_W-1:0] grp_thread, // Thread of the group
	input wire [`PSA_SLOTS-1:0] slot_used, // Slot holds an instruction
	input wire [`PSA_SLOTS*32-1:0] first_words, // First word per slot
	input wire [`PSA_SLOTS*32-1:0] second_words, // Second word per slot
	input wire [`PSA_SLOTS*32-1:0] src0_data, // Source 0 per slot
	input wire [`PSA_SLOTS*32-1:0] src1_data, // Source 1 per slot
	input wire [`PSA_THREAD_W-1:0] query_thread, // Thread whose predicate is read
	output reg res_valid_r, // Group results valid
	output reg [`PSA_THREAD_W-1:0] res_thread_r, // Thread of the results
	output reg [`PSA_SLOTS*32-1:0] res_data_r, // Destination value per slot
	output reg [`PSA_SLOTS-1:0] res_write_r, // Slot writes its destination
	output reg [`PSA_SLOTS-1:0] prev_valid_r, // Previous-result value valid
	output reg pred_update_r, // Group updated the predicate
	output reg pred_exec_r, // Group predicate: 1 execute, 0 skip
	output reg query_exec_r // Stored predicate of query_thread
);
	// ==========================================
	// Float helpers
	function is_nan;
		input [31:0] x;
		begin
			is_nan = (x[30:23] == 8'hff) && (x[22:0] != 23'h000000);
		end
	endfunction

	function fp_eq;
		input [31:0] a;
		input [31:0] b;
		begin
			if (is_nan(a) || is_nan(b)) begin
				fp_eq = 1'b0;
			end else if ((a[30:23] == 8'h00) && (b[30:23] == 8'h00)) begin
				fp_eq = 1'b1;
			end else begin
				fp_eq = (a == b);
			end
		end
	endfunction

	function fp_le;
		input [31:0] a;
		input [31:0] b;
		reg [30:0] ma;
		reg [30:0] mb;
		reg na;
		reg nb;
		begin
			ma = (a[30:23] == 8'h00) ? 31'h00000000 : a[30:0];
			mb = (b[30:23] == 8'h00) ? 31'h00000000 : b[30:0];
			na = a[31] && (ma != 31'h00000000);
			nb = b[31] && (mb != 31'h00000000);
			if (is_nan(a) || is_nan(b)) begin
				fp_le = 1'b0;
			end else if (na != nb) begin
				fp_le = na;
			end else if (na) begin
				fp_le = (ma >= mb);
			end else begin
				fp_le = (ma <= mb);
			end
		end
	endfunction

	function dbl_eq;
		input [63:0] a;
		input [63:0] b;
		reg nan_a;
		reg nan_b;
		begin
			nan_a = (a[62:52] == 11'h7ff) && (a[51:0] != 52'h0000000000000);
			nan_b = (b[62:52] == 11'h7ff) && (b[51:0] != 52'h0000000000000);
			if (nan_a || nan_b) begin
				dbl_eq = 1'b0;
			end else if ((a[62:52] == 11'h000) && (b[62:52] == 11'h000)) begin
				dbl_eq = 1'b1;
			end else begin
				dbl_eq = (a == b);
			end
		end
	endfunction

	// Output modifier as an exponent step; zero, denormal, inf and NaN pass
	function [31:0] apply_omod;
		input [31:0] x;
		input [1:0] om;
		reg [8:0] e;
		begin
			e = {1'b0, x[30:23]};
			apply_omod = x;
			if ((x[30:23] != 8'h00) && (x[30:23] != 8'hff)) begin
				case (om)
					`PSA_OMOD_MUL2: e = e + 9'h001;
					`PSA_OMOD_MUL4: e = e + 9'h002;
					`PSA_OMOD_DIV2: e = e - 9'h001;
					default: e = e;
				endcase
				if (e >= 9'h0ff) begin
					apply_omod = {x[31], 8'hff, 23'h000000};
				end else if (e == 9'h000) begin
					apply_omod = {x[31], 31'h00000000};
				end else begin
					apply_omod = {x[31], e[7:0], x[22:0]};
				end
			end
		end
	endfunction

	// ==========================================
	// Per-slot decode and operand modifiers
	wire [10:0] op_w [0:`PSA_SLOTS-1];
	wire [31:0] m0_w [0:`PSA_SLOTS-1];
	wire [31:0] m1_w [0:`PSA_SLOTS-1];
	wire [31:0] r0_w [0:`PSA_SLOTS-1];
	wire [31:0] r1_w [0:`PSA_SLOTS-1];
	wire [31:0] sum_w [0:`PSA_SLOTS-1];
	wire [31:0] dst_w [0:`PSA_SLOTS-1];
	wire [`PSA_SLOTS-1:0] wr_w;
	wire [`PSA_SLOTS-1:0] psel_w;
	wire [`PSA_SLOTS-1:0] pex_w;

	genvar gi;
	generate
		for (gi = 0; gi < `PSA_SLOTS; gi = gi + 1) begin : g_slot
			wire [31:0] w0 = first_words[gi*32 +: 32];
			wire [31:0] w1 = second_words[gi*32 +: 32];
			wire [31:0] add_a;
			wire [31:0] add_b;
			wire is_pop;
			wire is_dbl;
			wire lo_half;
			reg [31:0] dst;
			reg wr;
			reg psel;
			reg pex;
			assign op_w[gi] = w1[`PSA_W1_INST_HI:`PSA_W1_INST_LO];
			assign r0_w[gi] = src0_data[gi*32 +: 32];
			assign r1_w[gi] = src1_data[gi*32 +: 32];
			assign is_dbl = (op_w[gi] == `PSA_OP_PRED_DBL_EQ);
			// Odd slots carry the low dwords of a double: no modifiers there
			assign lo_half = is_dbl && ((gi % 2) == 1);
			assign m0_w[gi] = lo_half ? r0_w[gi] :
				({(r0_w[gi][31] & ~w1[`PSA_W1_SRC0_ABS]) ^ w0[`PSA_W0_SRC0_NEG],
				r0_w[gi][30:0]});
			assign m1_w[gi] = lo_half ? r1_w[gi] :
				({(r1_w[gi][31] & ~w1[`PSA_W1_SRC1_ABS]) ^ w0[`PSA_W0_SRC1_NEG],
				r1_w[gi][30:0]});
			// One adder serves pop (src0 - src1) and push (src0 + 1.0)
			assign is_pop = (op_w[gi] == `PSA_OP_PRED_POP);
			assign add_a = m0_w[gi];
			assign add_b = is_pop ? {~m1_w[gi][31], m1_w[gi][30:0]} : `PSA_F_ONE;
			psa_fadd u_add (
				.a(add_a),
				.b(add_b),
				.y(sum_w[gi])
			);
			assign dst_w[gi] = dst;
			assign wr_w[gi] = wr;
			assign psel_w[gi] = psel;
			assign pex_w[gi] = pex;
			always @* begin
				dst = `PSA_F_ZERO;
				wr = 1'b1;
				psel = 1'b0;
				pex = `PSA_PRED_SKIP;
				if (!slot_used[gi]) begin
					wr = 1'b0;
				end else begin
					case (op_w[gi])
						`PSA_OP_OR: begin
							dst = r0_w[gi] | r1_w[gi];
						end
						`PSA_OP_PRED_CLEAR: begin
							dst = `PSA_F_MAX;
							psel = 1'b1;
						end
						`PSA_OP_PRED_INVERT: begin
							psel = 1'b1;
							if (fp_eq(m0_w[gi], `PSA_F_ONE)) begin
								dst = `PSA_F_ZERO;
								pex = `PSA_PRED_EXEC;
							end else if (fp_eq(m0_w[gi], `PSA_F_ZERO)) begin
								dst = `PSA_F_ONE;
							end else begin
								dst = m0_w[gi];
							end
						end
						`PSA_OP_PRED_POP: begin
							psel = 1'b1;
							if (fp_le(m0_w[gi], m1_w[gi])) begin
								dst = `PSA_F_ZERO;
								pex = `PSA_PRED_EXEC;
							end else begin
								dst = sum_w[gi];
							end
						end
						`PSA_OP_PRED_RESTORE: begin
							// Predicate left as stored; source 0 passes through
							dst = m0_w[gi];
						end
						`PSA_OP_PRED_FP_EQ: begin
							psel = 1'b1;
							pex = fp_eq(m0_w[gi], m1_w[gi]);
							dst = pex ? `PSA_F_ZERO : `PSA_F_ONE;
						end
						`PSA_OP_PRED_INT_EQ: begin
							psel = 1'b1;
							pex = (r0_w[gi] == r1_w[gi]);
							dst = pex ? `PSA_F_ZERO : `PSA_F_ONE;
						end
						`PSA_OP_PRED_FP_PUSH_EQ: begin
							psel = 1'b1;
							pex = fp_eq(m1_w[gi], `PSA_F_ZERO) &&
								fp_eq(m0_w[gi], `PSA_F_ZERO);
							dst = pex ? `PSA_F_ZERO : sum_w[gi];
						end
						`PSA_OP_PRED_INT_PUSH_EQ: begin
							psel = 1'b1;
							pex = (r1_w[gi] == `PSA_I_ZERO) &&
								fp_eq(m0_w[gi], `PSA_F_ZERO);
							dst = pex ? `PSA_F_ZERO : sum_w[gi];
						end
						`PSA_OP_PRED_DBL_EQ: begin
							if (gi < 4) begin
								// Pair base holds the high dword, next slot the low
								psel = 1'b1;
								pex = dbl_eq(
									{m0_w[gi - (gi % 2)], m0_w[(gi - (gi % 2) + 1) % `PSA_SLOTS]},
									{m1_w[gi - (gi % 2)], m1_w[(gi - (gi % 2) + 1) % `PSA_SLOTS]});
								dst = pex ? `PSA_I_ZERO : `PSA_ALL_ONES;
							end else begin
								wr = 1'b0;
							end
						end
						default: begin
							wr = 1'b0;
						end
					endcase
				end
			end
		end
	endgenerate

	// ==========================================
	// Output modifiers and group predicate
	reg [`PSA_SLOTS*32-1:0] out_nxt;
	reg grp_pred_nxt;
	reg grp_psel_nxt;
	reg [1:0] om;
	integer si;

	always @* begin
		out_nxt = {(`PSA_SLOTS*32){1'b0}};
		grp_pred_nxt = `PSA_PRED_SKIP;
		grp_psel_nxt = 1'b0;
		om = 2'h0;
		for (si = 0; si < `PSA_SLOTS; si = si + 1) begin
			om = second_words[si*32 + `PSA_W1_OMOD_LO +: 2];
			if ((op_w[si] == `PSA_OP_PRED_DBL_EQ) || (op_w[si] == `PSA_OP_OR) ||
				(op_w[si] == `PSA_OP_PRED_INT_EQ)) begin
				out_nxt[si*32 +: 32] = dst_w[si];
			end else begin
				out_nxt[si*32 +: 32] = apply_omod(dst_w[si], om);
			end
		end
		// Lowest predicate slot wins; program keeps others out of a double group
		for (si = `PSA_SLOTS - 1; si >= 0; si = si - 1) begin
			if (psel_w[si] && slot_used[si]) begin
				grp_psel_nxt = 1'b1;
				grp_pred_nxt = pex_w[si];
			end
		end
	end

	// ==========================================
	// Group end registers and per-thread predicate store
	reg [`PSA_THREADS-1:0] pred_store_r;
	wire predicate_kill_update = grp_valid && grp_psel_nxt;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			res_valid_r <= 1'b0;
			res_thread_r <= {`PSA_THREAD_W{1'b0}};
			res_data_r <= {(`PSA_SLOTS*32){1'b0}};
			res_write_r <= {`PSA_SLOTS{1'b0}};
			prev_valid_r <= {`PSA_SLOTS{1'b0}};
			pred_update_r <= 1'b0;
			pred_exec_r <= `PSA_PRED_EXEC;
			pred_store_r <= {`PSA_THREADS{`PSA_PRED_EXEC}};
			query_exec_r <= `PSA_PRED_EXEC;
		end else begin
			res_valid_r <= grp_valid;
			query_exec_r <= pred_store_r[query_thread];
			pred_update_r <= predicate_kill_update;
			if (grp_valid) begin
				res_thread_r <= grp_thread;
				res_data_r <= out_nxt;
				res_write_r <= wr_w & slot_used;
				prev_valid_r <= wr_w & slot_used;
				if (grp_psel_nxt) begin
					pred_exec_r <= grp_pred_nxt;
				end
			end else begin
				res_write_r <= {`PSA_SLOTS{1'b0}};
			end
			if (predicate_kill_update) begin
				pred_store_r[grp_thread] <= grp_pred_nxt;
			end
		end
	end

endmodule

//--- test/psa_alu_sva.sv
// Checker for the predicate-set ALU slice, bound to its ports
`timescale 1ns/1ps
`include "psa_defines.vh"

module psa_alu_sva (
	input wire clock, // Core clock
	input wire rst_n, // Reset, active low
	input wire grp_valid, // Group presented
	input wire [5:0] grp_thread, // Thread of the group
	input wire [4:0] slot_used, // Slots in use
	input wire [159:0] first_words, // First words
	input wire [159:0] second_words, // Second words
	input wire [159:0] src0_data, // Source 0
	input wire [159:0] src1_data, // Source 1
	input wire [5:0] query_thread, // Queried thread
	input wire res_valid_r, // Results valid
	input wire [5:0] res_thread_r, // Result thread
	input wire [159:0] res_data_r, // Results
	input wire [4:0] res_write_r, // Slot writes
	input wire [4:0] prev_valid_r, // Previous values valid
	input wire pred_update_r, // Predicate updated
	input wire pred_exec_r, // Group predicate
	input wire query_exec_r // Stored predicate
);
	wire [10:0] op0 = second_words[17:7];
	wire [10:0] op1 = second_words[49:39];
	wire [1:0] omod0 = second_words[6:5];
	wire s0 = grp_valid && slot_used[0];

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	answer_next_a: assert property (grp_valid |=> res_valid_r)
		else $error("group not answered on the next edge");
	idle_quiet_a: assert property (!grp_valid |=> !res_valid_r && res_write_r == 5'h00)
		else $error("result strobes without a group");
	unused_slot_a: assert property (grp_valid |=> ((res_write_r | prev_valid_r)
		& ~$past(slot_used)) == 5'h00)
		else $error("unused slot wrote or kept previous value");
	result_thread_a: assert property (grp_valid |=> res_thread_r == $past(grp_thread))
		else $error("result thread differs from group thread");
	or_value_a: assert property (s0 && op0 == `PSA_OP_OR
		|=> res_data_r[31:0] == $past(src0_data[31:0] | src1_data[31:0]))
		else $error("or result wrong");
	clear_value_a: assert property (s0 && op0 == `PSA_OP_PRED_CLEAR && omod0 == 2'h0
		|=> res_data_r[31:0] == `PSA_F_MAX && !pred_exec_r && pred_update_r)
		else $error("clear result wrong");
	int_equal_a: assert property (s0 && op0 == `PSA_OP_PRED_INT_EQ |=> pred_update_r
		&& pred_exec_r == ($past(src0_data[31:0]) == $past(src1_data[31:0]))
		&& res_data_r[31:0] == (pred_exec_r ? `PSA_F_ZERO : `PSA_F_ONE))
		else $error("integer equal result wrong");
	double_pair_a: assert property (s0 && slot_used[1] && op0 == `PSA_OP_PRED_DBL_EQ
		&& op1 == `PSA_OP_PRED_DBL_EQ |=> res_data_r[31:0] == res_data_r[63:32]
		&& (res_data_r[31:0] == 32'h0 || res_data_r[31:0] == `PSA_ALL_ONES))
		else $error("double pair halves disagree");
	result_hold_a: assert property (!res_valid_r
		|-> $stable(pred_exec_r) && $stable(res_data_r))
		else $error("results changed without a group");
endmodule

bind psa_alu psa_alu_sva chk_u (.clock(clock), .rst_n(rst_n), .grp_valid(grp_valid),
	.grp_thread(grp_thread), .slot_used(slot_used), .first_words(first_words),
	.second_words(second_words), .src0_data(src0_data), .src1_data(src1_data),
	.query_thread(query_thread), .res_valid_r(res_valid_r), .res_thread_r(res_thread_r),
	.res_data_r(res_data_r), .res_write_r(res_write_r), .prev_valid_r(prev_valid_r),
	.pred_update_r(pred_update_r), .pred_exec_r(pred_exec_r), .query_exec_r(query_exec_r));

//--- test/psa_seq.sv
// Sequencer model issuing instruction groups to the ALU slice
`timescale 1ns/1ps
`include "psa_defines.vh"

module psa_seq (
	input wire clock, // Core clock
	output reg grp_valid, // Group presented
	output reg [5:0] grp_thread, // Thread of the group
	output reg [4:0] slot_used, // Slots in use
	output reg [159:0] first_words, // First words
	output reg [159:0] second_words, // Second words
	output reg [159:0] src0_data, // Source 0
	output reg [159:0] src1_data // Source 1
);
	initial begin
		grp_valid = 1'b0;
		grp_thread = 6'h00;
		slot_used = 5'h00;
		first_words = 160'h0;
		second_words = 160'h0;
		src0_data = 160'h0;
		src1_data = 160'h0;
	end

	// Callers keep double pairs on 0-1 or 2-3, no other predicate op beside them
	task put(input integer slot, input [10:0] op, input [31:0] a, input [31:0] b);
		begin
			slot_used[slot] = 1'b1;
			first_words[slot*32 +: 32] = 32'h00000000;
			second_words[slot*32 +: 32] = {14'h0000, op, 7'h00};
			src0_data[slot*32 +: 32] = a;
			src1_data[slot*32 +: 32] = b;
		end
	endtask

	// Source 0 negate and abs, and output modifier, of one slot after put
	task mods(input integer slot, input neg0, input abs0, input [1:0] om);
		begin
			first_words[slot*32 + `PSA_W0_SRC0_NEG] = neg0;
			second_words[slot*32 + `PSA_W1_SRC0_ABS] = abs0;
			second_words[slot*32 + `PSA_W1_OMOD_LO +: 2] = om;
		end
	endtask

	// One edge of group, then slots released with second words and sources scrambled, first words kept
	task go(input [5:0] thread);
		begin
			@(negedge clock);
			grp_thread = thread;
			grp_valid = 1'b1;
			@(negedge clock);
			grp_valid = 1'b0;
			slot_used = 5'h00;
			second_words = ~second_words;
			src0_data = ~src0_data;
			src1_data = ~src1_data;
		end
	endtask
endmodule

//--- test/psa_alu_tb.sv
// Testbench for the predicate-set ALU slice
`timescale 1ns/1ps
`include "psa_defines.vh"

module psa_alu_tb;
	reg clock = 1'b0;
	reg rst_n = 1'b0;
	reg [5:0] query_thread = 6'h01;
	wire grp_valid;
	wire [5:0] grp_thread;
	wire [4:0] slot_used;
	wire [159:0] first_words;
	wire [159:0] second_words;
	wire [159:0] src0_data;
	wire [159:0] src1_data;
	wire res_valid_r;
	wire [5:0] res_thread_r;
	wire [159:0] res_data_r;
	wire [4:0] res_write_r;
	wire [4:0] prev_valid_r;
	wire pred_update_r;
	wire pred_exec_r;
	wire query_exec_r;
	integer bad_count = 0;
	integer checks = 0;

	always #5 clock = ~clock;

	psa_seq seq_u (.clock(clock), .grp_valid(grp_valid), .grp_thread(grp_thread),
		.slot_used(slot_used), .first_words(first_words), .second_words(second_words),
		.src0_data(src0_data), .src1_data(src1_data));
	psa_alu dut_u (.clock(clock), .rst_n(rst_n), .grp_valid(grp_valid), .grp_thread(grp_thread),
		.slot_used(slot_used), .first_words(first_words), .second_words(second_words),
		.src0_data(src0_data), .src1_data(src1_data), .query_thread(query_thread),
		.res_valid_r(res_valid_r), .res_thread_r(res_thread_r), .res_data_r(res_data_r),
		.res_write_r(res_write_r), .prev_valid_r(prev_valid_r), .pred_update_r(pred_update_r),
		.pred_exec_r(pred_exec_r), .query_exec_r(query_exec_r));

	task chk(input string what, input [31:0] exp, input [31:0] got);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("mismatch %s expected %h seen %h", what, exp, got);
			end
		end
	endtask

	// Slot 0 alone, thread 1; checks value and predicate
	task one(input [10:0] op, input [31:0] a, input [31:0] b, input [31:0] d, input x);
		begin
			seq_u.put(0, op, a, b);
			seq_u.go(6'h01);
			chk("valid", 32'h1, 32'(res_valid_r));
			chk("data", d, res_data_r[31:0]);
			chk("update", 32'h1, 32'(pred_update_r));
			chk("exec", 32'(x), 32'(pred_exec_r));
		end
	endtask

	task s_or;
		begin
			seq_u.put(0, `PSA_OP_OR, 32'h0f0f0000, 32'h000000f5);
			seq_u.put(4, `PSA_OP_OR, 32'h80000001, 32'h00010000);
			seq_u.go(6'h2a);
			chk("or0", 32'h0f0f00f5, res_data_r[31:0]);
			chk("or4", 32'h80010001, res_data_r[159:128]);
			chk("thread", 32'h2a, 32'(res_thread_r));
			chk("update", 32'h0, 32'(pred_update_r));
		end
	endtask

	task s_pred;
		begin
			one(`PSA_OP_PRED_CLEAR, 32'h3f800000, 32'h0, `PSA_F_MAX, 1'b0);
			one(`PSA_OP_PRED_INVERT, `PSA_F_ONE, 32'h0, `PSA_F_ZERO, 1'b1);
			one(`PSA_OP_PRED_INVERT, `PSA_F_ZERO, 32'h0, `PSA_F_ONE, 1'b0);
			one(`PSA_OP_PRED_INVERT, 32'h40400000, 32'h0, 32'h40400000, 1'b0);
			one(`PSA_OP_PRED_POP, 32'h3f800000, 32'h40000000, `PSA_F_ZERO, 1'b1);
			one(`PSA_OP_PRED_POP, 32'h40400000, 32'h3f800000, 32'h40000000, 1'b0);
			one(`PSA_OP_PRED_FP_EQ, 32'h40400000, 32'h40400000, `PSA_F_ZERO, 1'b1);
			one(`PSA_OP_PRED_FP_EQ, 32'h3f800000, 32'h40000000, `PSA_F_ONE, 1'b0);
			one(`PSA_OP_PRED_FP_PUSH_EQ, 32'h0, 32'h0, `PSA_F_ZERO, 1'b1);
			one(`PSA_OP_PRED_FP_PUSH_EQ, `PSA_F_ONE, 32'h0, 32'h40000000, 1'b0);
			one(`PSA_OP_PRED_INT_PUSH_EQ, 32'h0, 32'h0, `PSA_F_ZERO, 1'b1);
			one(`PSA_OP_PRED_INT_PUSH_EQ, 32'h0, 32'h1, `PSA_F_ONE, 1'b0);
			one(`PSA_OP_PRED_INT_EQ, 32'h5, 32'h5, `PSA_F_ZERO, 1'b1);
			one(`PSA_OP_PRED_INT_EQ, 32'h5, 32'h6, `PSA_F_ONE, 1'b0);
			@(negedge clock);
			chk("query", 32'h0, 32'(query_exec_r));
		end
	endtask

	// Output modifier and abs on float compares; negate set on both double slots, applied only on the even one
	task s_mod;
		begin
			seq_u.put(0, `PSA_OP_PRED_FP_EQ, `PSA_F_ONE, 32'h40000000);
			seq_u.mods(0, 1'b0, 1'b0, `PSA_OMOD_MUL4);
			seq_u.put(2, `PSA_OP_PRED_FP_EQ, 32'hbf800000, `PSA_F_ONE);
			seq_u.mods(2, 1'b0, 1'b1, `PSA_OMOD_NONE);
			seq_u.go(6'h05);
			chk("omod", 32'h40800000, res_data_r[31:0]);
			chk("abs", `PSA_F_ZERO, res_data_r[95:64]);
			chk("exec", 32'h0, 32'(pred_exec_r));
			query_thread = 6'h05;
			@(negedge clock);
			chk("query", 32'h0, 32'(query_exec_r));
			seq_u.put(0, `PSA_OP_PRED_DBL_EQ, 32'hc0180000, 32'h40180000);
			seq_u.mods(0, 1'b1, 1'b0, `PSA_OMOD_NONE);
			seq_u.put(1, `PSA_OP_PRED_DBL_EQ, 32'h80000001, 32'h80000001);
			seq_u.mods(1, 1'b1, 1'b0, `PSA_OMOD_NONE);
			seq_u.go(6'h05);
			chk("dbl_mod0", 32'h0, res_data_r[31:0]);
			chk("dbl_mod1", 32'h0, res_data_r[63:32]);
			chk("exec", 32'h1, 32'(pred_exec_r));
		end
	endtask

	// Pair 0-1 equal, pair 2-3 unequal; then +0 against -0, NaN against NaN
	task s_dbl(input [31:0] a0, input [31:0] b0, input [31:0] a2, input [31:0] b2);
		integer i;
		begin
			seq_u.put(0, `PSA_OP_PRED_DBL_EQ, a0, b0);
			seq_u.put(1, `PSA_OP_PRED_DBL_EQ, 32'h0, 32'h0);
			seq_u.put(2, `PSA_OP_PRED_DBL_EQ, a2, b2);
			seq_u.put(3, `PSA_OP_PRED_DBL_EQ, 32'h0, 32'h0);
			seq_u.go(6'h03);
			for (i = 0; i < 4; i = i + 1) begin
				chk("dbl", (i < 2) ? 32'h0 : `PSA_ALL_ONES, res_data_r[i*32 +: 32]);
			end
			chk("exec", 32'h1, 32'(pred_exec_r));
		end
	endtask

	task s_nop;
		begin
			seq_u.put(0, `PSA_OP_PRED_RESTORE, 32'h40400000, 32'h0);
			seq_u.put(2, `PSA_OP_OR, 32'h1, 32'h2);
			seq_u.go(6'h04);
			chk("restore", 32'h40400000, res_data_r[31:0]);
			chk("write", 32'h05, 32'(res_write_r));
			chk("prev", 32'h05, 32'(prev_valid_r));
		end
	endtask

	task test_done;
		begin
			$display("checks %0d mismatches %0d", checks, bad_count);
			if (bad_count == 0 && checks > 0) begin
				$display("Finished cleanly");
			end else begin
				$display("Finished with errors");
			end
			$finish;
		end
	endtask

	initial begin
		repeat (5) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		chk("query", 32'h1, 32'(query_exec_r));
		s_or();
		s_pred();
		s_mod();
		s_dbl(32'h40180000, 32'h40180000, 32'h40080000, 32'h40180000);
		s_dbl(32'h00000000, 32'h80000000, 32'h7ff80000, 32'h7ff80000);
		s_nop();
		test_done();
	end

	initial begin
		repeat (3000) @(posedge clock);
		bad_count = bad_count + 1;
		test_done();
	end
endmodule
